/* hw/spf_framer.sv */
// Compact and header-full payload builder, header-full parser, with an Avalon-MM control slave
`timescale 1ns/1ps
`include "spf_cfg.svh"
module spf_framer
  import spf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        fin_valid,
  output logic             fin_ready,
  input  wire spf_ft_s     fin_ft,
  input  wire logic        fin_last,
  input  wire logic        spch_valid,
  output logic             spch_ready,
  input  wire logic [7:0]  spch_data,
  output logic             pkt_valid,
  input  wire logic        pkt_ready,
  output logic      [7:0]  pkt_data,
  output logic             pkt_first,
  output logic             pkt_last,
  output logic             pkt_compact,
  output logic             pkt_pbit,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic             dec_valid,
  input  wire logic        dec_ready,
  output logic      [7:0]  dec_data,
  output logic             dec_first,
  output logic             dec_last,
  output spf_ft_s          dec_ft,
  output logic             dec_bad,
  output logic             dec_empty
);
  localparam int NE = `SPF_MAX_ENT;

  // Speech bits per frame type, zero for lost, empty and reserved codes
  function automatic logic [11:0] ft_bits(input spf_ft_s f);
    logic [11:0] b;
    b = 12'h000;
    if (!f.mode)
      case (f.rate)
        4'h0: b = 12'h038;
        4'h1: b = 12'h090;
        4'h2: b = 12'h0A0;
        4'h3: b = 12'h0C0;
        4'h4: b = 12'h108;
        4'h5: b = 12'h148;
        4'h6: b = 12'h1E8;
        4'h7: b = 12'h280;
        4'h8: b = 12'h3C0;
        4'h9: b = 12'h500;
        4'hA: b = 12'h780;
        4'hB: b = 12'hA00;
        4'hC: b = 12'h030;
        default: b = 12'h000;
      endcase
    else
      case (f.rate)
        4'h0: b = 12'h084;
        4'h1: b = 12'h0B1;
        4'h2: b = 12'h0FD;
        4'h3: b = 12'h11D;
        4'h4: b = 12'h13D;
        4'h5: b = 12'h16D;
        4'h6: b = 12'h18D;
        4'h7: b = 12'h1CD;
        4'h8: b = 12'h1DD;
        4'h9: b = 12'h028;
        default: b = 12'h000;
      endcase
    return b;
  endfunction

  // Whole octets of a frame and the mask that zeroes unused tail bits
  function automatic logic [11:0] ft_bytes(input spf_ft_s f);
    logic [12:0] s;
    s = {1'b0, ft_bits(f)} + 13'h0007;
    return {2'b00, s[12:3]};
  endfunction
  function automatic logic [7:0] tail_mask(input spf_ft_s f);
    logic [11:0] t;
    logic [2:0]  r;
    t = ft_bits(f);
    r = t[2:0];
    return (r == 3'h0) ? 8'hFF : ~(8'hFF >> r);
  endfunction

  // Control and status registers
  logic [2:0]  ctrl_q;
  spf_cmr_s    cmr_q;
  logic [7:0]  rx_cmr_q;
  logic        rx_seen_q;
  logic        rx_err_q;
  logic [15:0] tx_pkts_q;
  logic [15:0] rx_bad_q;
  logic        ack_q;
  logic        full_header_only_option;
  logic        err_set;
  logic        bad_set;
  logic        pkt_done;
  logic        wr_fire;
  assign full_header_only_option = ctrl_q[`SPF_CTRL_FULL_HEADER_ONLY_OPTION];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_fire = avs_write & ack_q;

  // Bus answer: one wait cycle, then the access completes
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read & ~ack_q)
        case (avs_address)
          `SPF_OFS_CTRL: avs_readdata <= {29'h0, ctrl_q};
          `SPF_OFS_CMR:  avs_readdata <= {25'h0, cmr_q.req_type, cmr_q.req_mode};
          `SPF_OFS_STAT: avs_readdata <= {22'h0, rx_err_q, rx_seen_q, rx_cmr_q};
          `SPF_OFS_CNT:  avs_readdata <= {rx_bad_q, tx_pkts_q};
          default:       avs_readdata <= 32'h0000_0000;
        endcase
    end

  // Software-written configuration
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ctrl_q <= `SPF_CTRL_RST;
      cmr_q <= {1'b1, `SPF_CMR_RST};
    end
    else if (wr_fire && avs_byteenable[0])
    begin
      if (avs_address == `SPF_OFS_CTRL)
        ctrl_q <= avs_writedata[2:0];
      if (avs_address == `SPF_OFS_CMR)
        cmr_q <= {1'b1, avs_writedata[6:0]};
    end

  // Status: error flag set wins over write-one-to-clear
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      rx_err_q <= 1'b0;
      tx_pkts_q <= 16'h0000;
      rx_bad_q <= 16'h0000;
    end
    else
    begin
      if (err_set)
        rx_err_q <= 1'b1;
      else if (wr_fire && avs_address == `SPF_OFS_STAT && avs_byteenable[1]
               && avs_writedata[`SPF_STAT_ERR])
        rx_err_q <= 1'b0;
      if (pkt_done)
        tx_pkts_q <= tx_pkts_q + 16'h0001;
      if (bad_set)
        rx_bad_q <= rx_bad_q + 16'h0001;
    end

  // ---------------- Builder ----------------
  spf_tx_e     tx_q;
  spf_ft_s     ent_q [NE];
  logic [3:0]  n_q;
  logic [2:0]  idx_q;
  logic [2:0]  first_q;
  logic [2:0]  last_q;
  logic [11:0] rem_q;
  logic [11:0] size_q;
  logic [11:0] sent_q;
  logic        cmr_pend_q;
  logic        compact_q;
  logic        exempt_q;
  logic [NE-1:0] nd;
  logic [NE-1:0] hit;
  logic [2:0]  first_c;
  logic [2:0]  last_c;
  logic        any_c;
  logic [11:0] sum_c;
  logic        compact_c;
  logic        adv;
  logic        emit;
  logic [7:0]  emit_data;
  spf_kind_e   emit_kind;
  spf_kind_e   kind_q;
  logic [11:0] prot [NE];
  assign prot = '{`SPF_PROT_0, `SPF_PROT_1, `SPF_PROT_2, `SPF_PROT_3,
                  `SPF_PROT_4, `SPF_PROT_5, `SPF_PROT_6, `SPF_PROT_7};

  // Per entry: no-data marker and protected size match
  for (genvar gi = 0; gi < NE; gi++)
  begin : g_ent
    assign nd[gi] = (ent_q[gi].rate == `SPF_RATE_NODATA) || (4'(gi) >= n_q);
    assign hit[gi] = (size_q == prot[gi]);
  end

  // Trim leading and trailing no-data frames and total the speech bytes
  always_comb
  begin
    first_c = 3'h0;
    last_c = 3'h0;
    any_c = 1'b0;
    sum_c = 12'h000;
    for (int i = NE - 1; i >= 0; i--)
      if (!nd[i])
      begin
        first_c = 3'(i);
        any_c = 1'b1;
      end
    for (int i = 0; i < NE; i++)
      if (!nd[i])
        last_c = 3'(i);
    for (int i = 0; i < NE; i++)
      if (3'(i) >= first_c && 3'(i) <= last_c && any_c)
        sum_c = sum_c + ft_bytes(ent_q[i]);
    compact_c = !full_header_only_option && first_c == last_c &&
      ((!ent_q[first_c].mode && !ctrl_q[`SPF_CTRL_CMR_EN]) ||
       (ent_q[first_c].mode && ctrl_q[`SPF_CTRL_CMR_EN] &&
        !(cmr_q.req_type == `SPF_CMR_T_IO &&
          (cmr_q.req_mode == `SPF_CMR_D_1425 || cmr_q.req_mode == `SPF_CMR_D_1985))));
  end

  assign adv = ~pkt_valid | pkt_ready;
  assign fin_ready = (tx_q == TX_COLLECT);
  assign spch_ready = (tx_q == TX_SPEECH) && rem_q != 12'h000 && adv;

  // Byte to emit in the current state
  always_comb
  begin
    emit = 1'b0;
    emit_data = 8'h00;
    emit_kind = K_PAD;
    case (tx_q)
      TX_HDR:
      begin
        emit = adv;
        emit_kind = cmr_pend_q ? K_CMR : K_TOC;
        emit_data = cmr_pend_q ? cmr_q : {1'b0, idx_q != last_q, ent_q[idx_q]};
      end
      TX_SPEECH:
      begin
        emit_kind = (rem_q == 12'h000) ? K_PAD : K_SPH;
        emit = adv && ((rem_q != 12'h000 && spch_valid) || (rem_q == 12'h000 &&
               idx_q == last_q && sent_q != size_q));
        if (rem_q != 12'h000)
          emit_data = (rem_q == 12'h001) ? (spch_data & tail_mask(ent_q[idx_q])) : spch_data;
      end
      default: emit = 1'b0;
    endcase
  end
  assign pkt_done = emit && sent_q + 12'h001 == size_q;

  // Builder sequencing
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      tx_q <= TX_COLLECT;
      n_q <= 4'h0;
      idx_q <= 3'h0;
      first_q <= 3'h0;
      last_q <= 3'h0;
      rem_q <= 12'h000;
      size_q <= 12'h000;
      sent_q <= 12'h000;
      cmr_pend_q <= 1'b0;
      compact_q <= 1'b0;
      exempt_q <= 1'b0;
      for (int i = 0; i < NE; i++)
        ent_q[i] <= 6'h00;
    end
    else
    begin
      if (emit)
        sent_q <= sent_q + 12'h001;
      case (tx_q)
        TX_COLLECT:
          if (fin_valid)
          begin
            ent_q[n_q[2:0]] <= fin_ft;
            n_q <= n_q + 4'h1;
            if (fin_last || n_q == 4'(NE - 1))
              tx_q <= TX_PLAN;
          end
        TX_PLAN:
        begin
          first_q <= first_c;
          last_q <= last_c;
          idx_q <= first_c;
          compact_q <= compact_c;
          cmr_pend_q <= ctrl_q[`SPF_CTRL_CMR_EN] && !compact_c;
          exempt_q <= ctrl_q[`SPF_CTRL_CMR_EN] && first_c == last_c &&
                      ent_q[first_c].mode && ent_q[first_c].rate == `SPF_RATE_IO_SID;
          size_q <= sum_c + (compact_c ? 12'h000 :
                    12'(last_c - first_c) + 12'h001 + {11'h0, ctrl_q[`SPF_CTRL_CMR_EN]});
          sent_q <= 12'h000;
          rem_q <= ft_bytes(ent_q[first_c]);
          if (!any_c)
          begin
            n_q <= 4'h0;
            tx_q <= TX_COLLECT;
          end
          else
            tx_q <= compact_c ? TX_SPEECH : TX_SIZE;
        end
        TX_SIZE:
          if (!full_header_only_option && !exempt_q && |hit)
            size_q <= size_q + 12'h001;
          else
            tx_q <= TX_HDR;
        TX_HDR:
          if (emit)
          begin
            if (cmr_pend_q)
              cmr_pend_q <= 1'b0;
            else if (idx_q == last_q)
            begin
              idx_q <= first_q;
              tx_q <= TX_SPEECH;
            end
            else
              idx_q <= idx_q + 3'h1;
          end
        TX_SPEECH:
          if (rem_q != 12'h000)
          begin
            if (emit)
              rem_q <= rem_q - 12'h001;
          end
          else if (idx_q != last_q)
          begin
            idx_q <= idx_q + 3'h1;
            rem_q <= ft_bytes(ent_q[idx_q + 3'h1]);
          end
          else if (sent_q == size_q || pkt_done)
          begin
            n_q <= 4'h0;
            tx_q <= TX_COLLECT;
          end
        default: tx_q <= TX_COLLECT;
      endcase
    end

  // Registered packet output stage
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      pkt_valid <= 1'b0;
      pkt_data <= 8'h00;
      pkt_first <= 1'b0;
      pkt_last <= 1'b0;
      pkt_compact <= 1'b0;
      pkt_pbit <= 1'b0;
      kind_q <= K_PAD;
    end
    else if (adv)
    begin
      pkt_valid <= emit;
      pkt_data <= emit_data;
      pkt_first <= sent_q == 12'h000;
      pkt_last <= sent_q + 12'h001 == size_q;
      pkt_compact <= compact_q;
      pkt_pbit <= ctrl_q[`SPF_CTRL_PBIT];
      kind_q <= emit_kind;
    end

  // ---------------- Parser ----------------
  spf_rx_e     rxs_q;
  spf_ft_s     rent_q [NE];
  logic [3:0]  rn_q;
  logic [2:0]  ridx_q;
  logic [11:0] rrem_q;
  logic        rbeg_q;
  logic        rend_q;
  logic        dadv;
  logic        rx_fire;
  logic        ditem;
  logic        dend;
  spf_toc_s    rtoc;
  assign rtoc = rx_data;
  assign dadv = ~dec_valid | dec_ready;
  assign rx_ready = (rxs_q == RX_HDR) || (rxs_q == RX_DRAIN) ||
                    (rxs_q == RX_SPEECH && rrem_q != 12'h000 && dadv);
  assign rx_fire = rx_valid & rx_ready;
  assign ditem = (rxs_q == RX_SPEECH) && dadv && (rrem_q == 12'h000 || rx_valid);
  assign dend = rrem_q <= 12'h001;
  assign bad_set = ditem && rbeg_q && rent_q[ridx_q].mode && !rent_q[ridx_q].qbit;
  assign err_set = (rxs_q == RX_HDR && rx_fire &&
                    ((rtoc.hdr_type && rn_q != 4'h0) || (rx_last && rtoc.follow) ||
                     (!rtoc.hdr_type && rtoc.follow && rn_q == 4'(NE - 1)))) ||
                   (rxs_q == RX_SPEECH && rx_fire && rx_last && rrem_q > 12'h001);

  // Parser sequencing: headers, then speech per entry, then discard
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      rxs_q <= RX_HDR;
      rn_q <= 4'h0;
      ridx_q <= 3'h0;
      rrem_q <= 12'h000;
      rbeg_q <= 1'b1;
      rend_q <= 1'b0;
      rx_cmr_q <= 8'h00;
      rx_seen_q <= 1'b0;
      for (int i = 0; i < NE; i++)
        rent_q[i] <= 6'h00;
    end
    else
      case (rxs_q)
        RX_HDR:
          if (rx_fire)
          begin
            if (err_set)
            begin
              rn_q <= 4'h0;
              rxs_q <= rx_last ? RX_HDR : RX_DRAIN;
            end
            else if (rtoc.hdr_type)
            begin
              rx_cmr_q <= rx_data;
              rx_seen_q <= 1'b1;
            end
            else
            begin
              rent_q[rn_q[2:0]] <= rtoc.ft;
              rn_q <= rn_q + 4'h1;
              if (!rtoc.follow)
              begin
                ridx_q <= 3'h0;
                rrem_q <= (rn_q == 4'h0) ? ft_bytes(rtoc.ft) : ft_bytes(rent_q[0]);
                rbeg_q <= 1'b1;
                rend_q <= rx_last;
                rxs_q <= RX_SPEECH;
              end
            end
          end
        RX_SPEECH:
          if (ditem)
          begin
            rbeg_q <= 1'b0;
            if (rx_fire && rx_last)
              rend_q <= 1'b1;
            if (err_set)
            begin
              rn_q <= 4'h0;
              rxs_q <= RX_HDR;
            end
            else if (rrem_q > 12'h001)
              rrem_q <= rrem_q - 12'h001;
            else if (4'(ridx_q) + 4'h1 < rn_q)
            begin
              ridx_q <= ridx_q + 3'h1;
              rrem_q <= ft_bytes(rent_q[ridx_q + 3'h1]);
              rbeg_q <= 1'b1;
            end
            else
            begin
              rn_q <= 4'h0;
              rxs_q <= (rend_q || (rx_fire && rx_last)) ? RX_HDR : RX_DRAIN;
            end
          end
        RX_DRAIN:
          if (rx_fire && rx_last)
            rxs_q <= RX_HDR;
        default: rxs_q <= RX_HDR;
      endcase

  // Registered decoder output stage
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      dec_valid <= 1'b0;
      dec_data <= 8'h00;
      dec_first <= 1'b0;
      dec_last <= 1'b0;
      dec_ft <= 6'h00;
      dec_bad <= 1'b0;
      dec_empty <= 1'b0;
    end
    else if (dadv)
    begin
      dec_valid <= ditem;
      dec_data <= (rrem_q == 12'h001) ? (rx_data & tail_mask(rent_q[ridx_q])) :
                  (rrem_q == 12'h000) ? 8'h00 : rx_data;
      dec_first <= rbeg_q;
      dec_last <= dend;
      dec_ft <= rent_q[ridx_q];
      dec_bad <= rent_q[ridx_q].mode && !rent_q[ridx_q].qbit;
      dec_empty <= rrem_q == 12'h000;
    end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_cmr_taken;
    pkt_valid && pkt_ready && kind_q == K_CMR;
  endsequence
  sequence s_toc_next;
    pkt_valid && kind_q == K_TOC && !pkt_data[7];
  endsequence
  AST_TOC_TOP_ZERO: assert property (pkt_valid && kind_q == K_TOC |-> !pkt_data[7])
    else $error("entry byte top bit set");
  AST_TOC_LAST_FOLLOW: assert property (pkt_valid && kind_q == K_TOC && pkt_ready
    && $past(tx_q) == TX_HDR && tx_q == TX_SPEECH |-> !pkt_data[6] || $past(!adv))
    else $error("last entry has follow bit set");
  AST_NO_RSVD_RATE: assert property (pkt_valid && kind_q == K_TOC && !pkt_data[5]
    |-> pkt_data[3:0] != `SPF_RATE_RSVD)
    else $error("reserved rate code generated");
  AST_CMR_THEN_TOC: assert property (s_cmr_taken |=> s_toc_next)
    else $error("request byte not followed by an entry byte");
  AST_CMR_FIRST: assert property (pkt_valid && kind_q == K_CMR |-> pkt_first && pkt_data[7])
    else $error("request byte not first");
  AST_NO_PAD_HFONLY: assert property (tx_q == TX_SIZE && full_header_only_option |=> size_q == $past(size_q))
    else $error("collision padding under full-header-only");
  AST_SID_EXEMPT: assert property (tx_q == TX_SIZE && exempt_q |=> $stable(size_q))
    else $error("exempt comfort-noise payload padded");
  AST_BAD_FLAG: assert property (dec_valid && dec_ft.mode && !dec_ft.qbit |-> dec_bad)
    else $error("damaged interop frame not flagged");
  AST_NODATA_DROP: assert property (tx_q == TX_PLAN && !any_c |=> tx_q == TX_COLLECT
    ##1 !pkt_valid || $past(pkt_valid))
    else $error("all-empty packet not dropped");
  AST_DRAIN_QUIET: assert property (rxs_q == RX_DRAIN && dadv |=> !dec_valid)
    else $error("padding passed to decoder");
  AST_COMPACT_HF: assert property (tx_q == TX_PLAN && full_header_only_option |=> !compact_q)
    else $error("compact chosen under full-header-only");
endmodule

/* hw/spf_cfg.svh */
// Register map, field positions, reset values and code points of the payload framer
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH
`define SPF_OFS_CTRL     4'h0
`define SPF_OFS_CMR      4'h4
`define SPF_OFS_STAT     4'h8
`define SPF_OFS_CNT      4'hC
`define SPF_CTRL_FULL_HEADER_ONLY_OPTION 0
`define SPF_CTRL_CMR_EN  1
`define SPF_CTRL_PBIT    2
`define SPF_STAT_SEEN    8
`define SPF_STAT_ERR     9
`define SPF_CTRL_RST     3'h0
`define SPF_CMR_RST      7'h7F
`define SPF_MAX_ENT      8
`define SPF_RATE_PRI_SID 4'hC
`define SPF_RATE_RSVD    4'hD
`define SPF_RATE_LOST    4'hE
`define SPF_RATE_NODATA  4'hF
`define SPF_RATE_IO_SID  4'h9
`define SPF_CMR_T_IO     3'h1
`define SPF_CMR_D_1425   4'h3
`define SPF_CMR_D_1985   4'h6
`define SPF_PROT_0       12'h006
`define SPF_PROT_1       12'h007
`define SPF_PROT_2       12'h011
`define SPF_PROT_3       12'h012
`define SPF_PROT_4       12'h014
`define SPF_PROT_5       12'h017
`define SPF_PROT_6       12'h018
`define SPF_PROT_7       12'h020
`endif

/* hw/spf_pkg.sv */
// Types shared by the payload framer
package spf_pkg;
  typedef struct packed {
    logic       mode;
    logic       qbit;
    logic [3:0] rate;
  } spf_ft_s;
  typedef struct packed {
    logic    hdr_type;
    logic    follow;
    spf_ft_s ft;
  } spf_toc_s;
  typedef struct packed {
    logic       hdr_type;
    logic [2:0] req_type;
    logic [3:0] req_mode;
  } spf_cmr_s;
  typedef enum logic [4:0] {
    TX_COLLECT = 5'h01,
    TX_PLAN    = 5'h02,
    TX_SIZE    = 5'h04,
    TX_HDR     = 5'h08,
    TX_SPEECH  = 5'h10
  } spf_tx_e;
  typedef enum logic [3:0] {
    TX_PAD_NONE = 4'h0,
    TX_PAD      = 4'h1,
    TX_PAD_X    = 4'h2,
    TX_PAD_Y    = 4'h4
  } spf_unused_e;
  typedef enum logic [2:0] {
    RX_HDR    = 3'h1,
    RX_SPEECH = 3'h2,
    RX_DRAIN  = 3'h4
  } spf_rx_e;
  typedef enum logic [3:0] {
    K_CMR = 4'h1,
    K_TOC = 4'h2,
    K_SPH = 4'h4,
    K_PAD = 4'h8
  } spf_kind_e;
endpackage

/* tb/spf_far.sv */
// Far-side transport model that loops each built non-compact payload back in
`timescale 1ns/1ps
module spf_far
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       pkt_valid,
  output logic            pkt_ready,
  input  wire logic [7:0] pkt_data,
  input  wire logic       pkt_last,
  input  wire logic       pkt_compact,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_last
);
  logic [7:0] q[$];
  int         n;
  // Stores whole payloads, replays them, stalls the builder every other cycle when idle
  always @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      n = 0;
      pkt_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= 8'h00;
    end
    else
    begin
      if (rx_valid && rx_ready)
      begin
        void'(q.pop_front());
        n--;
      end
      if (pkt_valid && pkt_ready && !pkt_compact)
        q.push_back(pkt_data);
      if (pkt_valid && pkt_ready && pkt_last && !pkt_compact)
        n = q.size();
      pkt_ready <= !pkt_ready || n > 0;
      rx_valid <= n > 0;
      rx_last <= n == 1;
      rx_data <= n > 0 ? q[0] : ~rx_data; // Released line keeps changing
    end
endmodule

/* tb/spf_framer_tb.sv */
// Testbench of the payload framer against a queue-based reference
`timescale 1ns/1ps
`include "spf_cfg.svh"
module spf_framer_tb
  import spf_pkg::*;
;
  logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, fin_valid, fin_ready;
  logic        fin_last, spch_valid, spch_ready, pkt_valid, pkt_ready, pkt_first, pkt_last;
  logic        pkt_compact, pkt_pbit, rx_valid, rx_ready, rx_last, dec_valid, dec_ready;
  logic        dec_first, dec_last, dec_bad, dec_empty;
  logic [3:0]  avs_address;
  logic [7:0]  spch_data, pkt_data, rx_data, dec_data;
  logic [31:0] avs_writedata, avs_readdata, rd;
  spf_ft_s     fin_ft, dec_ft;
  logic [5:0]  ft_q[$];
  logic [11:0] exp_pkt[$];
  logic [17:0] exp_dec[$];
  int          mismatches, checked, seed;

  spf_framer i_spf_framer (.avs_byteenable(4'hF), .*);
  spf_far    i_spf_far (.*);

  // Free-running system clock
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0 && ++t < 99);
    if (t >= 99) mismatches++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic hs(ref logic r);
    int t;
    t = 0;
    do @(posedge clk_sys); while (r !== 1'b1 && ++t < 999);
    if (t >= 999) mismatches++;
  endtask

  function automatic int bits(input logic [5:0] f);
    return f == 6'h00 ? 56 : f == 6'h01 ? 144 : f[5] && f[3:0] == 4'h0 ? 132 : 0;
  endfunction

  // Builds the reference payload and decoder items, then feeds the frames
  task automatic run(input logic hf, input logic ce);
    int         nb, u;
    logic       cp, any;
    logic [7:0] b[$];
    logic [7:0] s[$];
    bus(1'b1, `SPF_OFS_CTRL, {29'h0, hf, ce, hf});
    cp = !hf && !ce && ft_q.size() == 1 && !ft_q[0][5];
    any = 1'b0;
    if (ce && !cp) b.push_back(8'h93);
    foreach (ft_q[i])
    begin
      any |= ft_q[i][3:0] != 4'hF;
      if (!cp) b.push_back({1'b0, i != ft_q.size() - 1, ft_q[i]});
    end
    foreach (ft_q[i])
    begin
      u = bits(ft_q[i]);
      nb = (u + 7) / 8;
      for (int j = 0; j < nb; j++)
      begin
        s.push_back(8'($random(seed)));
        b.push_back(s[$] & (u - 8 * j >= 8 ? 8'hFF : 8'hFF << (8 * j + 8 - u)));
        if (!cp) exp_dec.push_back({j == 0, j == nb - 1, ft_q[i][5] && !ft_q[i][4],
                                    1'b0, ft_q[i], b[$]});
      end
      if (nb == 0) exp_dec.push_back({2'b00, 1'b0, 1'b1, ft_q[i], 8'h00});
    end
    while (!hf && !cp && b.size() inside {`SPF_PROT_0, `SPF_PROT_1, `SPF_PROT_2, `SPF_PROT_3,
           `SPF_PROT_4, `SPF_PROT_5, `SPF_PROT_6, `SPF_PROT_7}) b.push_back(8'h00);
    if (!any) exp_dec.delete();
    if (any) foreach (b[i]) exp_pkt.push_back({hf, i == 0, i == b.size() - 1, cp, b[i]});
    foreach (ft_q[i])
    begin
      @(posedge clk_sys);
      fin_valid <= 1'b1;
      fin_ft <= spf_ft_s'(ft_q[i]);
      fin_last <= i == ft_q.size() - 1;
      hs(fin_ready);
      fin_valid <= 1'b0;
    end
    foreach (s[i])
    begin
      @(posedge clk_sys);
      spch_valid <= 1'b1;
      spch_data <= s[i];
      hs(spch_ready);
      spch_valid <= 1'b0;
    end
    for (int t = 0; t < 999 && exp_pkt.size() + exp_dec.size() > 0; t++) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    cmp("pending items", 0, exp_pkt.size() + exp_dec.size());
  endtask

  // Scores accepted packet bytes and decoder items
  always @(posedge clk_sys)
    if (rst === 1'b0)
    begin
      if (pkt_valid === 1'b1 && pkt_ready === 1'b1)
        cmp("packet byte", exp_pkt.size() ? exp_pkt.pop_front() : '1,
            {pkt_pbit, pkt_first, pkt_last, pkt_compact, pkt_data});
      if (dec_valid === 1'b1 && dec_ready === 1'b1)
        cmp("decoder item", exp_dec.size() ? exp_dec.pop_front() : '1,
            {dec_empty ? 2'b00 : {dec_first, dec_last}, dec_bad, dec_empty, dec_ft,
             dec_data});
    end

  // Random back-pressure from the decoder
  always @(posedge clk_sys) dec_ready <= ($random(seed) & 3) != 0;

  // Main sequence
  initial
  begin
    seed = 32'h37b8593c;
    {mismatches, checked} = 0;
    {rst, avs_read, avs_write, fin_valid, fin_last, spch_valid, dec_ready} = 7'h41;
    {avs_address, avs_writedata, spch_data, fin_ft} = 50'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, `SPF_OFS_CMR, 32'h0);
    cmp("request reset", `SPF_CMR_RST, rd);
    bus(1'b0, 4'h2, 32'h0);
    cmp("unmapped read", 0, rd);
    bus(1'b1, `SPF_OFS_CMR, 32'h13);
    ft_q = '{6'h00, 6'h0E, 6'h20};
    run(1'b1, 1'b0);
    ft_q = '{6'h00, 6'h00};
    run(1'b1, 1'b1);
    bus(1'b0, `SPF_OFS_STAT, 32'h0);
    cmp("status", 32'h193, rd);
    run(1'b0, 1'b1);
    ft_q = '{6'h0F, 6'h2F};
    run(1'b0, 1'b0);
    ft_q = '{6'h01};
    run(1'b0, 1'b0);
    bus(1'b0, `SPF_OFS_CNT, 32'h0);
    cmp("counters", 32'h0001_0004, rd);
    tally_and_finish;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish;
  end
endmodule
